// ### mms_mgmt.sv
// management-serial master, bus splitter and internal register slave
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module mms_mgmt
  import mms_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // static configuration
  input  wire logic        host_en_in,
  input  wire logic        mgmt_enable_attr_in,
  input  wire logic        ignore_address_zero_in,
  input  wire logic [4:0]  internal_slave_phy_address_in,
  input  wire logic        sgmii_mode_in,
  // management configuration register write
  input  wire logic        cfg_we_in,
  input  wire logic [5:0]  cfg_div_in,
  input  wire logic        cfg_mgmt_en_in,
  // host frame request
  input  wire logic        req_in,
  input  wire logic        req_write_in,
  input  wire logic [4:0]  req_phy_in,
  input  wire logic [4:0]  req_reg_in,
  input  wire logic [15:0] req_wdata_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      rdata_out,
  // management pins
  output logic             mgmt_clock_out,
  input  wire logic        mgmt_data_in,
  output logic             mgmt_data_out,
  output logic             mgmt_data_tristate_out,
  input  wire logic        mgmt_clock_in_alt_in,
  // internal sublayer controls
  output logic [15:0]      pcs_control_out,
  output logic [15:0]      loopback_control_out
);

  mms_state_t r;
  mms_state_t n;

  logic        mg_en;
  logic        run;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        bus;
  logic [12:0] hdr;
  logic        hit;
  logic [15:0] rx_word;

  // ----------------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------------
  function automatic logic [15:0] reg_read(input mms_state_t s, input logic [4:0] a,
                                           input logic sgmii);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      MMS_REG_PCS_CONTROL:    v = (s.ctrl & MMS_CTRL_WMASK) | MMS_CTRL_FIXED;
      MMS_REG_PCS_STATUS:     v = MMS_STATUS_VAL;
      MMS_REG_IDENT_HIGH:     v = MMS_IDENT_HIGH;
      MMS_REG_IDENT_LOW:      v = MMS_IDENT_LOW;
      MMS_REG_AN_ADVERTISE:   v = sgmii ? MMS_ADV_SGMII : s.adv;
      MMS_REG_AN_PARTNER:     v = 16'h0000;
      MMS_REG_AN_EXPANSION:   v = 16'h0000;
      MMS_REG_NP_TRANSMIT:    v = s.nptx;
      MMS_REG_NP_RECEIVE:     v = 16'h0000;
      MMS_REG_EXT_STATUS:     v = MMS_EXT_STATUS;
      MMS_REG_AN_IRQ_CONTROL: v = s.irqc;
      MMS_REG_LOOPBACK:       v = s.loopc;
      default:                v = 16'h0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    n      = r;
    n.done = 1'b0;

    // pins pass three flops; a change counts once the last two agree
    n.dsync = {r.dsync[1:0], mgmt_data_in};
    n.csync = {r.csync[1:0], mgmt_clock_in_alt_in};
    if (r.dsync[1] == r.dsync[2]) begin
      n.din = r.dsync[2];
    end
    if (r.csync[1] == r.csync[2]) begin
      n.cin = r.csync[2];
    end

    if (cfg_we_in) begin
      n.div    = cfg_div_in;
      n.cfg_en = cfg_mgmt_en_in;
    end

    mg_en = (mgmt_enable_attr_in | r.cfg_en) & (r.div != MMS_DIV_RESET);
    run   = mg_en & host_en_in;
    tick  = run & (r.dcnt == r.div);

    // clock divider: a half period is div+1 host cycles
    if (run) begin
      if (tick) begin
        n.dcnt = 6'h00;
        n.mdc  = ~r.mdc;
      end else begin
        n.dcnt = r.dcnt + 6'h01;
      end
    end else begin
      n.dcnt = 6'h00;
      n.mdc  = 1'b0;
    end

    // with the host side off the outside master's clock times the slave,
    // and the divided clock output stays low
    if (host_en_in) begin
      rise = tick & ~r.mdc;
      fall = tick & r.mdc;
    end else begin
      rise = n.cin & ~r.cin;
      fall = ~n.cin & r.cin;
    end

    // shared line seen by master and slave: open wired-and of all drivers
    bus = (r.moe ? r.msh[63] : 1'b1) & (r.soe ? r.sdrv : 1'b1) & r.din;

    // ---------------- master ----------------
    // start only in the low phase right after a fall, so bit 0 is set up
    if (req_in && !r.mbusy && run && !r.mdc && r.dcnt == 6'h00) begin
      n.mbusy = 1'b1;
      n.mread = ~req_write_in;
      n.moe   = 1'b1;
      n.mbit  = 6'h00;
      n.msh   = {MMS_PREAMBLE, MMS_START, req_write_in ? MMS_OP_WRITE : MMS_OP_READ,
                 req_phy_in, req_reg_in, MMS_TA_DRIVE, req_wdata_in};
    end else if (r.mbusy && !run) begin
      n.mbusy = 1'b0;
      n.moe   = 1'b0;
    end else if (r.mbusy && fall) begin
      if (r.mbit == MMS_BIT_LAST) begin
        n.mbusy = 1'b0;
        n.moe   = 1'b0;
        n.done  = 1'b1;
        if (r.mread) begin
          n.rdata = r.mrd;
        end
      end else begin
        n.mbit = r.mbit + 6'h01;
        n.msh  = {r.msh[62:0], 1'b1};
        if (r.mread && n.mbit == MMS_BIT_TA1) begin
          n.moe = 1'b0;
        end
      end
    end else if (r.mbusy && rise && r.mread && r.mbit >= MMS_BIT_DATA) begin
      n.mrd = {r.mrd[14:0], bus};
    end

    // ---------------- internal slave ----------------
    hdr     = {r.shdr[11:0], bus};
    hit     = hdr[12] & ((hdr[9:5] == internal_slave_phy_address_in)
              | ((hdr[9:5] == MMS_PHY_ZERO) & ~ignore_address_zero_in));
    rx_word = {r.sdat[14:0], bus};

    if (!mg_en) begin
      n.sst  = MMS_SL_IDLE;
      n.soe  = 1'b0;
      n.prev = 1'b0;
    end else if (rise) begin
      case (r.sst)
        MMS_SL_IDLE: begin
          n.prev = bus;
          if (r.prev && !bus) begin
            n.sst  = MMS_SL_HDR;
            n.scnt = 5'h00;
          end
        end
        MMS_SL_HDR: begin
          n.shdr = hdr;
          n.scnt = r.scnt + 5'h01;
          if (r.scnt == MMS_HDR_LAST) begin
            n.scnt = 5'h00;
            if (hit && hdr[11:10] == MMS_OP_READ) begin
              n.sst  = MMS_SL_RD;
              n.sdat = reg_read(r, hdr[4:0], sgmii_mode_in);
            end else begin
              // other frames are counted through so their data cannot fake a start
              n.sst  = MMS_SL_RX;
              n.shit = hit & (hdr[11:10] == MMS_OP_WRITE);
            end
          end
        end
        MMS_SL_RX: begin
          n.sdat = rx_word;
          n.scnt = r.scnt + 5'h01;
          if (r.scnt == MMS_RX_LAST) begin
            n.sst  = MMS_SL_IDLE;
            n.prev = 1'b0;
            if (r.shit) begin
              case (r.shdr[4:0])
                MMS_REG_PCS_CONTROL:    n.ctrl  = rx_word & MMS_CTRL_WMASK;
                MMS_REG_AN_ADVERTISE:   n.adv   = sgmii_mode_in ? r.adv : rx_word;
                MMS_REG_NP_TRANSMIT:    n.nptx  = rx_word;
                MMS_REG_AN_IRQ_CONTROL: n.irqc  = rx_word;
                MMS_REG_LOOPBACK:       n.loopc = rx_word;
                default:                n.shit  = 1'b0;
              endcase
            end
          end
        end
        MMS_SL_RD: begin
          n.scnt = r.scnt;
        end
        default: n.sst = MMS_SL_IDLE;
      endcase
    end else if (fall && r.sst == MMS_SL_RD) begin
      n.scnt = r.scnt + 5'h01;
      if (r.scnt == MMS_RD_TA2) begin
        n.soe  = 1'b1;
        n.sdrv = 1'b0;
      end else if (r.scnt >= MMS_RD_D0 && r.scnt < MMS_RD_END) begin
        n.sdrv = r.sdat[15];
        n.sdat = {r.sdat[14:0], 1'b0};
      end else if (r.scnt == MMS_RD_END) begin
        n.soe  = 1'b0;
        n.sst  = MMS_SL_IDLE;
        n.prev = 1'b0;
      end
    end

    // pins carry whichever of master and slave drives the line
    n.pin_tri = ~(n.moe | n.soe);
    n.pin_out = (n.moe ? n.msh[63] : 1'b1) & (n.soe ? n.sdrv : 1'b1);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r         <= '0;
      r.div     <= MMS_DIV_RESET;
      r.dsync   <= '1;
      r.din     <= 1'b1;
      r.ctrl    <= MMS_CTRL_RESET;
      r.adv     <= MMS_ADV_RESET;
      r.pin_out <= 1'b1;
      r.pin_tri <= 1'b1;
      r.msh     <= '1;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign busy_out               = r.mbusy;
  assign done_out               = r.done;
  assign rdata_out              = r.rdata;
  assign mgmt_clock_out         = r.mdc;
  assign mgmt_data_out          = r.pin_out;
  assign mgmt_data_tristate_out = r.pin_tri;
  assign pcs_control_out        = r.ctrl;
  assign loopback_control_out   = r.loopc;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence hdr_done;
    ce_in && mg_en && rise && r.sst == MMS_SL_HDR && r.scnt == MMS_HDR_LAST;
  endsequence

  sequence loop_write;
    ce_in && mg_en && rise && r.sst == MMS_SL_RX && r.scnt == MMS_RX_LAST && r.shit
      && r.shdr[4:0] == MMS_REG_LOOPBACK;
  endsequence

  chk_clock_idle: assert property (ce_in && !run |=> !mgmt_clock_out)
    else $error("management clock toggles while disabled");

  chk_half_period: assert property (ce_in && run && r.dcnt != r.div |=>
    r.mdc == $past(r.mdc) && r.dcnt == $past(r.dcnt) + 6'h01)
    else $error("management clock half period wrong");

  chk_div_zero: assert property (r.div == MMS_DIV_RESET && !r.mbusy |=> !r.mbusy)
    else $error("frame started with zero divider");

  chk_frame_end: assert property (ce_in && run && fall && r.mbusy
    && r.mbit == MMS_BIT_LAST |=> done_out && !busy_out)
    else $error("frame did not end after last bit");

  chk_master_release: assert property (r.mbusy && r.mread && r.mbit >= MMS_BIT_TA1
    |-> !r.moe)
    else $error("master drives line during read answer");

  chk_slave_ta: assert property (ce_in && mg_en && fall && r.sst == MMS_SL_RD
    && r.scnt == MMS_RD_TA2 |=> r.soe && !r.sdrv ##1 r.soe)
    else $error("slave missed turnaround drive");

  chk_addr_miss: assert property (hdr_done ##0 !hit |=> r.sst == MMS_SL_RX && !r.shit)
    else $error("slave answered foreign address");

  chk_zero_addr: assert property (hdr_done ##0 hdr[12] && hdr[9:5] == MMS_PHY_ZERO
    && ignore_address_zero_in && internal_slave_phy_address_in != MMS_PHY_ZERO
    |=> r.sst == MMS_SL_RX && !r.shit)
    else $error("slave answered ignored address zero");

  chk_loop_write: assert property (loop_write |=> r.loopc == $past(rx_word))
    else $error("loopback register write lost");

  chk_unmapped_read: assert property (hdr_done ##0 hit && hdr[11:10] == MMS_OP_READ
    && hdr[4:0] == 5'h09 |=> r.sdat == 16'h0000)
    else $error("unmapped register read not zero");

endmodule // mms_mgmt

// ### mms_pkg.sv
// package for the management-serial master and internal register slave
package mms_pkg;

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam logic [31:0] MMS_PREAMBLE  = 32'hffffffff;
  localparam logic [1:0]  MMS_START     = 2'h1;
  localparam logic [1:0]  MMS_OP_WRITE  = 2'h1;
  localparam logic [1:0]  MMS_OP_READ   = 2'h2;
  localparam logic [1:0]  MMS_TA_DRIVE  = 2'h2;
  localparam logic [5:0]  MMS_BIT_TA1   = 6'h2e;
  localparam logic [5:0]  MMS_BIT_DATA  = 6'h30;
  localparam logic [5:0]  MMS_BIT_LAST  = 6'h3f;
  localparam logic [4:0]  MMS_HDR_LAST  = 5'h0c;
  localparam logic [4:0]  MMS_RX_LAST   = 5'h11;
  localparam logic [4:0]  MMS_RD_TA2    = 5'h01;
  localparam logic [4:0]  MMS_RD_D0     = 5'h02;
  localparam logic [4:0]  MMS_RD_END    = 5'h12;
  localparam logic [4:0]  MMS_PHY_ZERO  = 5'h00;
  localparam logic [5:0]  MMS_DIV_RESET = 6'h00;

  // ------------------------------------------------------------------
  // internal slave register map
  // ------------------------------------------------------------------
  localparam logic [4:0] MMS_REG_PCS_CONTROL    = 5'h00;
  localparam logic [4:0] MMS_REG_PCS_STATUS     = 5'h01;
  localparam logic [4:0] MMS_REG_IDENT_HIGH     = 5'h02;
  localparam logic [4:0] MMS_REG_IDENT_LOW      = 5'h03;
  localparam logic [4:0] MMS_REG_AN_ADVERTISE   = 5'h04;
  localparam logic [4:0] MMS_REG_AN_PARTNER     = 5'h05;
  localparam logic [4:0] MMS_REG_AN_EXPANSION   = 5'h06;
  localparam logic [4:0] MMS_REG_NP_TRANSMIT    = 5'h07;
  localparam logic [4:0] MMS_REG_NP_RECEIVE     = 5'h08;
  localparam logic [4:0] MMS_REG_EXT_STATUS     = 5'h0f;
  localparam logic [4:0] MMS_REG_AN_IRQ_CONTROL = 5'h10;
  localparam logic [4:0] MMS_REG_LOOPBACK       = 5'h11;

  localparam logic [15:0] MMS_CTRL_WMASK   = 16'h5c20;
  localparam logic [15:0] MMS_CTRL_FIXED   = 16'h0140;
  localparam logic [15:0] MMS_CTRL_RESET   = 16'h0000;
  localparam logic [15:0] MMS_STATUS_VAL   = 16'h01c8;
  localparam logic [15:0] MMS_EXT_STATUS   = 16'h8000;
  localparam logic [15:0] MMS_ADV_RESET    = 16'h0020;
  localparam logic [15:0] MMS_ADV_SGMII    = 16'h0001;
  // identifier words: arbitrary values
  localparam logic [15:0] MMS_IDENT_HIGH   = 16'h1234;
  localparam logic [15:0] MMS_IDENT_LOW    = 16'h5670;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {MMS_SL_IDLE, MMS_SL_HDR, MMS_SL_RX, MMS_SL_RD} mms_sl_state_t;

  typedef struct packed {
    logic [2:0]    dsync;
    logic          din;
    logic [2:0]    csync;
    logic          cin;
    logic [5:0]    div;
    logic          cfg_en;
    logic [5:0]    dcnt;
    logic          mdc;
    logic          mbusy;
    logic          mread;
    logic          moe;
    logic [63:0]   msh;
    logic [5:0]    mbit;
    logic [15:0]   mrd;
    logic          done;
    logic [15:0]   rdata;
    mms_sl_state_t sst;
    logic          prev;
    logic [4:0]    scnt;
    logic [12:0]   shdr;
    logic [15:0]   sdat;
    logic          shit;
    logic          soe;
    logic          sdrv;
    logic [15:0]   ctrl;
    logic [15:0]   adv;
    logic [15:0]   nptx;
    logic [15:0]   irqc;
    logic [15:0]   loopc;
    logic          pin_out;
    logic          pin_tri;
  } mms_state_t;

endpackage

// ### mms_phy_model.sv
// behavioural external management slave standing on the shared data line
`timescale 1ns/1ps
module mms_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h09
) (
  // bus side
  input  wire logic mdc_in,
  input  wire logic line_in,
  output logic      oe_out,
  output logic      d_out
);
  logic [15:0] mem [32];
  logic [3:0]  hist;
  logic [11:0] hdr;
  logic [15:0] wsh;
  logic        act;
  logic        hit;
  int          cnt;

  assign hit = act && hdr[9:5] == PHY_ADDR;

  initial begin
    act = 1'b0;
    hist = 4'h0;
    oe_out = 1'b0;
    d_out = 1'b1;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // sample on the rising clock; start is ones then 0 then 1
  always @(posedge mdc_in) begin
    if (!act) begin
      hist = {hist[2:0], line_in};
      if (hist == 4'hd) begin
        act = 1'b1;
        cnt = 0;
      end
    end else begin
      cnt++;
      if (cnt <= 12) hdr = {hdr[10:0], line_in};
      else if (cnt >= 15) wsh = {wsh[14:0], line_in};
      if (cnt == 30) begin
        if (hit && hdr[11:10] == 2'h1) mem[hdr[4:0]] = wsh;
        act = 1'b0;
        hist = 4'h0;
      end
    end
  end

  // drive on the falling clock; released line shows a changing value behind oe
  always @(negedge mdc_in) begin
    if (act && hit && hdr[11:10] == 2'h2 && cnt >= 13) begin
      oe_out <= 1'b1;
      d_out  <= (cnt == 13) ? 1'b0 : mem[hdr[4:0]][29 - cnt];
    end else begin
      oe_out <= 1'b0;
      d_out  <= ~d_out;
    end
  end
endmodule // mms_phy_model

// ### test_mms_mgmt.sv
// self-checking bench for the management master and internal slave
`timescale 1ns/1ps
module test_mms_mgmt;
  import mms_pkg::*;
  localparam logic [4:0] PHY_ADDR = 5'h09;
  logic clk, rst_n, ce, host_en, attr, ign, sgm, cfg_we, cfg_en, req, rw;
  logic busy, done, mclk, dout, dtri, alt_clk, om_oe, om_d, phy_oe, phy_d;
  logic line, mclk_d, busy_at, mclk_off, hen_d;
  logic [4:0]  sadr, rphy, rreg;
  logic [5:0]  cfg_div, div_now, d;
  logic [15:0] rwd, rdata, pcs, loop, v, r;
  logic [15:0] val [32];
  int          miscompares, num_checks, cycles, per;

  // ------------------------------------------------------------
  // design, partner and shared line
  // ------------------------------------------------------------
  mms_mgmt DUT (.clock_in(clk), .rst_n_in(rst_n), .ce_in(ce), .host_en_in(host_en),
    .mgmt_enable_attr_in(attr), .ignore_address_zero_in(ign),
    .internal_slave_phy_address_in(sadr), .sgmii_mode_in(sgm), .cfg_we_in(cfg_we),
    .cfg_div_in(cfg_div), .cfg_mgmt_en_in(cfg_en), .req_in(req), .req_write_in(rw),
    .req_phy_in(rphy), .req_reg_in(rreg), .req_wdata_in(rwd), .busy_out(busy),
    .done_out(done), .rdata_out(rdata), .mgmt_clock_out(mclk), .mgmt_data_in(line),
    .mgmt_data_out(dout), .mgmt_data_tristate_out(dtri),
    .mgmt_clock_in_alt_in(alt_clk), .pcs_control_out(pcs), .loopback_control_out(loop));
  mms_phy_model #(.PHY_ADDR(PHY_ADDR)) phy (.mdc_in(mclk), .line_in(line),
    .oe_out(phy_oe), .d_out(phy_d));
  // pull-up when nobody drives the joined line
  assign line = !dtri ? dout : phy_oe ? phy_d : om_oe ? om_d : 1'b1;

  // ------------------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // fields held until busy rises; called at a falling edge
  task automatic frame(input logic wr, input logic [4:0] ph, rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    int n;
    req = 1'b1; rw = wr; rphy = ph; rreg = rg; rwd = wd;
    n = 0;
    while (busy !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    req = 1'b0;
    while (done !== 1'b1 && n < 4000) begin @(negedge clk); n++; end
    check("frame done", {15'h0, done}, 16'h0001);
    rd = rdata;
    @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] ph, rg, input logic [15:0] wd);
    logic [15:0] x;
    frame(1'b1, ph, rg, wd, x);
  endtask

  task automatic rd_check(input string what, input logic [4:0] ph, rg, input logic [15:0] e);
    logic [15:0] x;
    frame(1'b0, ph, rg, 16'h0000, x);
    check(what, x, e);
  endtask

  task automatic cfg(input logic [5:0] dv, input logic en);
    cfg_we = 1'b1; cfg_div = dv; cfg_en = en; div_now = dv;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask

  // outside master: slow clock so the slave's input filters keep up
  task automatic om_frame(input logic [1:0] op, input logic [4:0] rg,
                          input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {MMS_PREAMBLE, MMS_START, op, sadr, rg, MMS_TA_DRIVE, wd};
    for (int i = 63; i >= 0; i--) begin
      alt_clk = 1'b0;
      om_oe = (op == MMS_OP_WRITE) || i > 17;
      om_d = f[i];
      repeat (10) @(negedge clk);
      if (i < 16) rd[i] = line;
      alt_clk = 1'b1;
      repeat (10) @(negedge clk);
    end
    alt_clk = 1'b0;
    om_oe = 1'b0;
    // let the slave see the closing fall before anything else moves
    repeat (10) @(negedge clk);
  endtask

  function automatic logic [15:0] ro_exp(input logic [4:0] rg);
    case (rg)
      MMS_REG_PCS_STATUS: return MMS_STATUS_VAL;
      MMS_REG_IDENT_HIGH: return MMS_IDENT_HIGH;
      MMS_REG_IDENT_LOW:  return MMS_IDENT_LOW;
      MMS_REG_EXT_STATUS: return MMS_EXT_STATUS;
      default:            return 16'h0000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // clock, watchdog and clock-period monitor
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // sampled on the falling edge, away from the edge that moves the outputs
  always @(negedge clk) begin
    cycles++;
    if (cycles > 80000) begin
      miscompares++;
      finish_test();
    end
    per++;
    if (!busy) busy_at = 1'b0;
    // the clock stops one edge after the host side goes off
    if (!host_en && !hen_d && mclk) mclk_off = 1'b1;
    hen_d = host_en;
    if (mclk && !mclk_d) begin
      if (busy && busy_at) check("clock period", per[15:0], 16'(2 * (div_now + 1)));
      per = 0;
      busy_at = busy;
    end
    mclk_d = mclk;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    // outside clock input rests low while the host side drives
    {rst_n, attr, ign, sgm, cfg_we, cfg_en, req, rw, alt_clk, om_oe, om_d} = '0;
    {ce, host_en} = 2'h3;
    {rphy, rreg, rwd, cfg_div, div_now, mclk_d, busy_at, mclk_off} = '0;
    sadr = 5'h01;
    hen_d = 1'b1;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    void'($urandom(83));
    sadr = 5'($urandom_range(1, 8));
    // slow enough divides keep the clock within the protocol limit
    d = 6'($urandom_range(9, 10));
    check("control reset", pcs, MMS_CTRL_RESET);
    cfg(MMS_DIV_RESET, 1'b1);
    req = 1'b1; rw = 1'b0; rphy = sadr; rreg = MMS_REG_LOOPBACK;
    repeat (100) @(negedge clk);
    check("busy, zero divider", {15'h0, busy}, 16'h0000);
    cfg(d, 1'b0);
    repeat (100) @(negedge clk);
    check("busy, no enable", {15'h0, busy}, 16'h0000);
    req = 1'b0;
    attr = 1'b1;
    foreach (val[i]) val[i] = 16'($urandom);
    foreach (val[i]) if (i inside {4, 7, 16, 17}) begin
      if (i == 16) begin
        attr = 1'b0;
        cfg(d, 1'b1);
      end
      wr(sadr, 5'(i), val[i]);
      rd_check("rw register", sadr, 5'(i), val[i]);
    end
    v = 16'($urandom);
    wr(sadr, MMS_REG_PCS_CONTROL, v);
    rd_check("control", sadr, MMS_REG_PCS_CONTROL, (v & MMS_CTRL_WMASK) | MMS_CTRL_FIXED);
    check("control out", pcs, v & MMS_CTRL_WMASK);
    foreach (val[i]) if (i inside {1, 2, 3, 5, 6, 8, 15}) begin
      wr(sadr, 5'(i), 16'hffff);
      rd_check("read-only", sadr, 5'(i), ro_exp(5'(i)));
    end
    foreach (val[i]) if (i inside {9, 14, 18, 31}) begin
      wr(sadr, 5'(i), 16'hffff);
      rd_check("unmapped", sadr, 5'(i), 16'h0000);
    end
    rd_check("address zero", MMS_PHY_ZERO, MMS_REG_LOOPBACK, val[17]);
    ign = 1'b1;
    rd_check("address zero ignored", MMS_PHY_ZERO, MMS_REG_LOOPBACK, 16'hffff);
    rd_check("own address", sadr, MMS_REG_LOOPBACK, val[17]);
    rd_check("other address", sadr + 5'h10, MMS_REG_LOOPBACK, 16'hffff);
    ign = 1'b0;
    sgm = 1'b1;
    wr(sadr, MMS_REG_AN_ADVERTISE, 16'($urandom));
    rd_check("sgmii advertise", sadr, MMS_REG_AN_ADVERTISE, MMS_ADV_SGMII);
    sgm = 1'b0;
    rd_check("advertise kept", sadr, MMS_REG_AN_ADVERTISE, val[4]);
    v = 16'($urandom);
    wr(PHY_ADDR, 5'($urandom), v);
    rd_check("external device", PHY_ADDR, rreg, v);
    host_en = 1'b0;
    v = 16'($urandom);
    om_frame(MMS_OP_WRITE, MMS_REG_LOOPBACK, v, r);
    om_frame(MMS_OP_READ, MMS_REG_LOOPBACK, 16'h0000, r);
    check("outside read", r, v);
    check("loopback out", loop, v);
    check("clock quiet", {15'h0, mclk_off}, 16'h0000);
    host_en = 1'b1;
    rd_check("host after outside", sadr, MMS_REG_LOOPBACK, v);
    finish_test();
  end
endmodule // test_mms_mgmt
